//--- logic/keysearch_pkg.sv
// Constants and carriers for the disc keysearch sequencer.
// Assumes a single 20 MHz clock domain shared by bus and disc logic.
`default_nettype none
package keysearch_pkg;
   // AXI4-Lite register byte addresses
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] RESULT_ADDR = 8'h08;
   localparam logic [7:0] COUNT_ADDR  = 8'h0C;
   // Control register fields
   localparam int CTRL_GO_BIT     = 0;
   localparam int CTRL_RESULT_BIT = 1;
   // DMA microprogram steps
   localparam logic [5:0] STEP_JUMP_FROM = 6'd10;
   localparam logic [5:0] STEP_END_ADDR  = 6'd23;
   localparam logic [5:0] STEP_ZERO_KS   = 6'd24;
   localparam logic [5:0] STEP_BRANCH_TEST     = 6'd25;
   localparam logic [5:0] STEP_FETCH     = 6'd26;
   localparam logic [5:0] STEP_SAVE_HI   = 6'd28;
   localparam logic [5:0] STEP_FETCH_LO  = 6'd29;
   localparam logic [5:0] STEP_STORE_N   = 6'd31;
   localparam logic [5:0] STEP_FETCH_NS  = 6'd33;
   localparam logic [5:0] STEP_STORE_NS  = 6'd35;
   localparam logic [5:0] STEP_LOAD_S    = 6'd36;
   localparam logic [5:0] STEP_SAVE_ADDR = 6'd37;
   localparam logic [5:0] STEP_RELOAD    = 6'd38;
   localparam logic [5:0] STEP_IDLE      = 6'd39;
   localparam logic [5:0] STEP_WR_KEY    = 6'd40;
   localparam logic [5:0] STEP_STORE_S   = 6'd41;
   localparam logic [5:0] STEP_LOAD_END  = 6'd42;
   localparam logic [5:0] STEP_TEST_END  = 6'd43;
   localparam logic [5:0] STEP_RESULT    = 6'd46;
   localparam logic [5:0] STEP_HALT      = 6'd63;
   // Keysearch microprogram steps
   localparam logic [5:0] KS_ZERO_BKN = 6'd0;
   localparam logic [5:0] KS_ZERO_K   = 6'd1;
   localparam logic [5:0] KS_WAIT_SYN = 6'd2;
   localparam logic [5:0] KS_READCHK  = 6'd3;
   localparam logic [5:0] KS_WAIT_SEC = 6'd4;
   localparam logic [5:0] KS_WAIT_BYT = 6'd6;
   localparam logic [5:0] KS_COMPARE  = 6'd8;
   localparam logic [5:0] KS_STORE    = 6'd9;
   localparam logic [5:0] KS_LOOP     = 6'd11;
   localparam logic [5:0] KS_KEY_DONE = 6'd12;
   localparam logic [5:0] KS_HALT     = 6'd31;
   localparam logic [5:0] KS_SECTOR   = 6'd20;
   localparam logic [5:0] KS_SEC_CMP  = 6'd24;
   // Scratch pad slots
   localparam logic [3:0] SLOT_ADDR = 4'd0;
   localparam logic [3:0] SLOT_END  = 4'd1;
   localparam logic [3:0] SLOT_SIZE = 4'd2;
   localparam logic [3:0] SLOT_N    = 4'd3;
   localparam logic [3:0] SLOT_K    = 4'd4;
   localparam logic [3:0] SLOT_NS   = 4'd6;
   localparam logic [3:0] SLOT_BKN  = 4'd7;
   localparam logic [3:0] SLOT_KS   = 4'd8;
   // Sizes and timing
   localparam int         FIFO_DEPTH  = 64;
   localparam int         MAX_KEY     = 49;
   localparam logic [1:0] HOLD_CYCLES = 2'd2;
   localparam logic [3:0] BYTE_BITS   = 4'd8;
   localparam logic [7:0] PREAMBLE_BYTES = 8'd31;
   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_DECERR = 2'b11;

   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        strobe;
   } dma_req_s;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_DMA  = 3'b010,
      SEQ_KEY  = 3'b100
   } seq_mode_e;
endpackage
`default_nettype wire

//--- logic/disc_key_search_sequencer.sv
// Keysearch sequencer: DMA parameter fetch,
// argument key load and byte-serial key compare.
// Assumes bus and DMA answer on ref_clk;
// drive pins pass the synchronisers below.
//
// Summary of operation
// [R01] Step 10 jumps to 23; 23 saves end address
// [R02] Step 24 zeroes key size, slot 2
// [R03] Step 25: result mode to 46, else 26
// [R04] Step 26 DMA fetch; two hold clocks after byte
// [R05] Step 28 saves next address in slot 0
// [R06] Key count to slot 3, B cleared, per-sector to slot 6
// [R07] Step 36 loads key size; counted and written back
// [R08] Argument keys are 49 bytes at most; the code never checks MAX_KEY, and arg_cnt_q counts to 63 into 64-entry FIFOs
// [R09] Step 37 saves address, 38 reloads, 39 idles
// [R10] Step 40 stores key byte; 41 saves size; 42 end address
// [R11] Step 43: address-equal halts at 63, else to 36
// [R12] Search: 0 zeroes slot 7, 1 slot 4, 2 awaits sync
// [R13] Step 3 sets operation and read latches; errors ignored
// [R14] Zero per key byte in best FIFO A; bytes recirculate
// [R15] One best FIFO supplies, other stores; swap on trial best
// [R16] Read gate on: read clock shifts bits; 8 make a byte
// [R17] Byte ready sets step 7, step 8 a clock later; FIFO heads compared, recirculated
// [R18] Two latch pairs; first unequal byte locks each pair
// [R19] Both within-bounds mean trial best; step 9 stores byte
// [R20] Byte count equals key size: step 12, else 11 to 6
// [R21] Steps 12-15 count keys in slot 4, best in 7; halt at 31
// [R22] Steps 20-24 count sector keys in slot 8 against slot 6
`timescale 1ns/100ps
`default_nettype none
module disc_key_search_sequencer
   import keysearch_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // CPU memory DMA side
   output var  dma_req_s    dma_req,
   input  wire logic        dma_done,
   input  wire logic [7:0]  dma_data,
   // Disc drive side
   input  wire logic        sector_minus_one_sync_n,
   input  wire logic        sector_pulse_n,
   input  wire logic        drive_read_clock,
   input  wire logic        drive_read_bit,
   output var  logic        disc_read_gate,
   output var  logic        search_done
);
   // Two-flop synchronisers on all drive pins
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic       rclk_prev_q;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q    <= 4'h0;
         pin_s2_q    <= 4'h0;
         rclk_prev_q <= 1'b0;
      end
      else
      begin
         pin_s1_q    <= {~sector_minus_one_sync_n, ~sector_pulse_n,
                         drive_read_clock, drive_read_bit};
         pin_s2_q    <= pin_s1_q;
         rclk_prev_q <= pin_s2_q[1];
      end
   end
   logic syn_m1;
   logic sec_pls;
   logic rclk_rise;
   assign syn_m1    = pin_s2_q[3];
   assign sec_pls   = pin_s2_q[2];
   assign rclk_rise = pin_s2_q[1] & ~rclk_prev_q;

   // Registers and storage
   seq_mode_e   mode_q;
   logic [5:0]  step_q;
   logic [15:0] a_reg_q;
   logic [15:0] b_reg_q;
   logic [15:0] scratch_q [0:15];
   logic [7:0]  arg_fifo_q [0:FIFO_DEPTH-1];
   logic [7:0]  best_fifo_q [0:1][0:FIFO_DEPTH-1];
   logic [5:0]  arg_cnt_q;
   logic [5:0]  byte_idx_q;
   logic        best_sel_q;   // FIFO now supplying comparison bytes
   logic [1:0]  hold_q;
   logic        wait_dma_q;
   logic        result_mode_q;
   logic        addr_equal_q;
   logic        op_latch_q;
   logic        read_enable_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  preamble_q;
   logic [7:0]  shift_q;
   logic [7:0]  out_byte_q;
   logic        byte_ready_q;
   logic [3:0]  cmp_q;        // {c_in, c_out, b_in, b_out}
   logic        trial_best_flag;
   logic [15:0] start_addr_q;
   logic [15:0] end_addr_q;
   logic        go_q;

   assign trial_best_flag = cmp_q[3] & cmp_q[1]; // [R19]

   // Byte compare helper: 2'b10 greater, 2'b01 less, 2'b00 equal
   function automatic logic [1:0] byte_cmp(input logic [7:0] x,
                                           input logic [7:0] y);
      byte_cmp = {x > y, x < y};
   endfunction

   // Bit assembly; preamble bytes dropped
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt_q    <= 4'h0;
         shift_q      <= 8'h00;
         out_byte_q   <= 8'h00;
         byte_ready_q <= 1'b0;
         preamble_q   <= 8'h00;
      end
      else
      begin
         byte_ready_q <= 1'b0;
         if (!read_enable_q)
         begin
            bit_cnt_q  <= 4'h0;
            preamble_q <= 8'h00;
         end
         else if (rclk_rise) // [R16]
         begin
            shift_q <= {shift_q[6:0], pin_s2_q[0]};
            if (bit_cnt_q == BYTE_BITS - 4'd1)
            begin
               bit_cnt_q <= 4'h0;
               if (preamble_q == PREAMBLE_BYTES)
               begin
                  byte_ready_q <= 1'b1; // [R16]
                  out_byte_q   <= {shift_q[6:0], pin_s2_q[0]};
               end
               else
                  preamble_q <= preamble_q + 8'd1;
            end
            else
               bit_cnt_q <= bit_cnt_q + 4'd1;
         end
      end
   end

   // Microprogram sequencer and data path
   logic [7:0] arg_head;
   logic [7:0] best_head;
   assign arg_head  = arg_fifo_q[0];
   assign best_head = best_fifo_q[best_sel_q][0];

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q        <= SEQ_IDLE;
         step_q        <= 6'd0;
         a_reg_q       <= 16'h0000;
         b_reg_q       <= 16'h0000;
         hold_q        <= 2'd0;
         wait_dma_q    <= 1'b0;
         addr_equal_q  <= 1'b0;
         op_latch_q    <= 1'b0;
         read_enable_q <= 1'b0;
         cmp_q         <= 4'h0;
         best_sel_q    <= 1'b0;
         arg_cnt_q     <= 6'd0;
         byte_idx_q    <= 6'd0;
         dma_req       <= '0;
         search_done   <= 1'b0;
         for (int i = 0; i < 16; i++)
            scratch_q[i] <= 16'h0000;
      end
      else
      begin
         dma_req.strobe <= 1'b0;
         case (mode_q)
         SEQ_IDLE:
         begin
            if (go_q)
            begin
               mode_q      <= SEQ_DMA;
               search_done <= 1'b0;
               a_reg_q     <= start_addr_q;
               b_reg_q     <= end_addr_q;
               arg_cnt_q   <= 6'd0;
               addr_equal_q <= 1'b0;
               step_q      <= STEP_JUMP_FROM;
            end
         end
         SEQ_DMA:
         begin
            if (wait_dma_q)
            begin
               if (dma_done)
               begin
                  wait_dma_q <= 1'b0;
                  dma_req.rd <= 1'b0;
                  hold_q     <= HOLD_CYCLES; // [R04]
                  b_reg_q    <= {8'h00, dma_data};
               end
            end
            else if (hold_q != 2'd0)
               hold_q <= hold_q - 2'd1; // [R04]
            else
            begin
               step_q <= step_q + 6'd1;
               case (step_q)
               STEP_JUMP_FROM: step_q <= STEP_END_ADDR; // [R01]
               STEP_END_ADDR: scratch_q[SLOT_END] <= b_reg_q; // [R01]
               STEP_ZERO_KS: scratch_q[SLOT_SIZE] <= 16'h0000; // [R02]
               STEP_BRANCH_TEST: // [R03]
                  if (result_mode_q)
                     step_q <= STEP_RESULT;
               STEP_FETCH, STEP_FETCH_LO, STEP_FETCH_NS, STEP_RELOAD:
               begin
                  // [R04] [R09]
                  dma_req.addr   <= a_reg_q;
                  dma_req.rd     <= 1'b1;
                  dma_req.strobe <= 1'b1;
                  wait_dma_q     <= 1'b1;
               end
               STEP_SAVE_HI, STEP_SAVE_ADDR:
               begin
                  // [R05] [R09]
                  a_reg_q              <= a_reg_q + 16'd1;
                  scratch_q[SLOT_ADDR] <= a_reg_q + 16'd1;
               end
               STEP_STORE_N:
               begin
                  scratch_q[SLOT_N] <= b_reg_q; // [R06]
                  b_reg_q           <= 16'h0000;
                  a_reg_q           <= a_reg_q + 16'd1;
                  step_q            <= STEP_FETCH_NS;
               end
               STEP_STORE_NS:
                  scratch_q[SLOT_NS] <= b_reg_q; // [R06]
               STEP_LOAD_S: b_reg_q <= scratch_q[SLOT_SIZE]; // [R07]
               STEP_IDLE: ; // [R09]
               STEP_WR_KEY:
               begin
                  // [R10] [R14] [R08]
                  arg_fifo_q[arg_cnt_q]        <= b_reg_q[7:0];
                  best_fifo_q[0][arg_cnt_q]    <= 8'h00;
                  arg_cnt_q                    <= arg_cnt_q + 6'd1;
                  b_reg_q <= {10'h000, arg_cnt_q} + 16'd1; // [R07]
               end
               STEP_STORE_S: scratch_q[SLOT_SIZE] <= b_reg_q; // [R10]
               STEP_LOAD_END: b_reg_q <= scratch_q[SLOT_END]; // [R10]
               STEP_TEST_END: // [R11]
                  if (a_reg_q == b_reg_q)
                  begin
                     addr_equal_q <= 1'b1;
                     step_q       <= STEP_HALT;
                  end
                  else
                     step_q <= STEP_LOAD_S;
               STEP_RESULT: mode_q <= SEQ_IDLE;
               STEP_HALT:
               begin
                  mode_q     <= SEQ_KEY; // [R12]
                  step_q     <= KS_ZERO_BKN;
                  best_sel_q <= 1'b0;
               end
               default: ;
               endcase
            end
         end
         SEQ_KEY:
         begin
            step_q <= step_q + 6'd1;
            case (step_q)
            KS_ZERO_BKN: scratch_q[SLOT_BKN] <= 16'h0000; // [R12]
            KS_ZERO_K: scratch_q[SLOT_K] <= 16'h0000; // [R12]
            KS_WAIT_SYN:
               if (!syn_m1)
                  step_q <= KS_WAIT_SYN; // [R12]
            KS_READCHK:
            begin
               op_latch_q    <= 1'b1; // [R13]
               read_enable_q <= 1'b1;
            end
            KS_WAIT_SEC:
            begin
               scratch_q[SLOT_KS] <= 16'h0000; // [R22]
               if (!sec_pls)
                  step_q <= KS_WAIT_SEC;
            end
            6'd5: byte_idx_q <= 6'd0;
            KS_WAIT_BYT:
               if (!byte_ready_q)
                  step_q <= KS_WAIT_BYT;
            6'd7: ;
            KS_COMPARE:
            begin
               // [R17] [R18] first unequal byte decides
               if (cmp_q[3:2] == 2'b00)
                  cmp_q[3:2] <= byte_cmp(arg_head, out_byte_q);
               if (cmp_q[1:0] == 2'b00)
                  cmp_q[1:0] <= byte_cmp(out_byte_q, best_head);
               for (int i = 0; i < FIFO_DEPTH - 1; i++)
               begin
                  arg_fifo_q[i]              <= arg_fifo_q[i+1];
                  best_fifo_q[best_sel_q][i] <= best_fifo_q[best_sel_q][i+1];
               end
               // [R14] recirculate at key tail
               arg_fifo_q[arg_cnt_q-6'd1] <= arg_head;
               best_fifo_q[best_sel_q][arg_cnt_q-6'd1] <= best_head;
            end
            KS_STORE:
            begin
               best_fifo_q[~best_sel_q][byte_idx_q] <= out_byte_q; // [R19]
               byte_idx_q <= byte_idx_q + 6'd1;
            end
            6'd10: ;
            KS_LOOP: // [R20]
               if (byte_idx_q != scratch_q[SLOT_SIZE][5:0])
                  step_q <= KS_WAIT_BYT;
            KS_KEY_DONE:
            begin
               // [R21] steps 12 to 15 folded
               scratch_q[SLOT_K] <= scratch_q[SLOT_K] + 16'd1;
               if (trial_best_flag)
               begin
                  scratch_q[SLOT_BKN] <= scratch_q[SLOT_K] + 16'd1;
                  best_sel_q          <= ~best_sel_q; // [R15]
               end
               cmp_q  <= 4'h0;
               step_q <= (scratch_q[SLOT_K] + 16'd1 == scratch_q[SLOT_N])
                         ? KS_HALT : KS_SECTOR;
            end
            KS_SECTOR:
               scratch_q[SLOT_KS] <= scratch_q[SLOT_KS] + 16'd1; // [R22]
            KS_SEC_CMP - 6'd3, KS_SEC_CMP - 6'd2, KS_SEC_CMP - 6'd1: ;
            KS_SEC_CMP: // [R22]
               step_q <= (scratch_q[SLOT_KS] == scratch_q[SLOT_NS])
                         ? KS_WAIT_SEC : KS_WAIT_BYT;
            KS_HALT:
            begin
               read_enable_q <= 1'b0; // [R21]
               op_latch_q    <= 1'b0;
               search_done   <= 1'b1;
               mode_q        <= SEQ_IDLE;
            end
            default: step_q <= KS_HALT;
            endcase
         end
         default: mode_q <= SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         disc_read_gate <= 1'b0;
      else
         disc_read_gate <= read_enable_q; // [R16]
   end

   // AXI4-Lite write; both channels taken together
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
         go_q          <= 1'b0;
         result_mode_q <= 1'b0;
         start_addr_q  <= 16'h0000;
         end_addr_q    <= 16'h0000;
      end
      else
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         go_q          <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                  && !s_axi_awready)
         begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= AXI_OKAY;
            case (s_axi_awaddr)
            CTRL_ADDR:
            begin
               go_q          <= s_axi_wdata[CTRL_GO_BIT] & s_axi_wstrb[0];
               result_mode_q <= s_axi_wdata[CTRL_RESULT_BIT];
            end
            COUNT_ADDR:
            begin
               start_addr_q <= s_axi_wdata[15:0];
               end_addr_q   <= s_axi_wdata[31:16];
            end
            STATUS_ADDR, RESULT_ADDR: ;
            default: s_axi_bresp <= AXI_DECERR;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
         begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= AXI_OKAY;
            case (s_axi_araddr)
            CTRL_ADDR: s_axi_rdata <= {30'h0, result_mode_q, 1'b0};
            STATUS_ADDR: s_axi_rdata <= {16'h0, mode_q, best_sel_q,
                                         addr_equal_q, op_latch_q,
                                         search_done, step_q, 3'h0};
            RESULT_ADDR: s_axi_rdata <= {scratch_q[SLOT_K],
                                         scratch_q[SLOT_BKN]};
            COUNT_ADDR: s_axi_rdata <= {end_addr_q, start_addr_q};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= AXI_DECERR;
            end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/dma_memory_model.sv
// CPU memory partner: answers each DMA read strobe with one byte.
// Assumes the bench preloads mem and shares ref_clk with the design.
`timescale 1ns/100ps
`default_nettype none
module dma_memory_model
   import keysearch_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire dma_req_s   dma_req,
   output var  logic       dma_done,
   output var  logic [7:0] dma_data
);
   logic [7:0] mem [0:511];
   int         wait_q;

   // Random answer delay; the data line toggles when not valid
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dma_done <= 1'b0;
         dma_data <= 8'h00;
         wait_q   <= -1;
      end
      else
      begin
         dma_done <= 1'b0;
         dma_data <= ~dma_data;
         if (dma_req.strobe)
            wait_q <= $urandom_range(4);
         else if (wait_q == 0)
         begin
            dma_done <= 1'b1;
            dma_data <= mem[dma_req.addr[8:0]];
         end
         if (wait_q >= 0 && !dma_req.strobe)
            wait_q <= wait_q - 1;
      end
   end
endmodule
`default_nettype wire

//--- sim/key_search_assertions.sv
// Port checker for the sequencer, bound below.
// Assumes one clock and async low reset.
`timescale 1ns/100ps
`default_nettype none
module key_search_checker
   import keysearch_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire dma_req_s    dma_req,
   input wire logic        dma_done,
   input wire logic        search_done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Bus answers stand until taken
   a_bvalid_holds: assert property
      (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer moved");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[0:1] s_axi_bvalid)
      else $error("bvalid late");
   // DMA fetch: one strobe, steady address till answered
   a_strobe_pulse: assert property (dma_req.strobe |=> !dma_req.strobe)
      else $error("strobe too long");
   a_strobe_reads: assert property (dma_req.strobe |-> dma_req.rd)
      else $error("strobe no read");
   a_addr_steady: assert property (dma_req.strobe |=>
      (dma_req.rd && $stable(dma_req.addr)) until dma_done)
      else $error("fetch address moved");
   a_hold_two: assert property (dma_done |=> !dma_req.strobe [*2])
      else $error("fetch in hold");
   a_done_stays: assert property (search_done && !s_axi_awvalid
      |=> search_done)
      else $error("done dropped");
   c_fetch: cover property (dma_done);
   c_done: cover property ($rose(search_done));
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind disc_key_search_sequencer key_search_checker u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .dma_req(dma_req), .dma_done(dma_done), .search_done(search_done));
`default_nettype wire

//--- sim/tb_disc_key_search_sequencer.sv
// Bench: AXI4-Lite set-up, DMA partner, serial disc keys.
// Assumes keysearch_pkg; checked against an integer model.
`timescale 1ns/100ps
`default_nettype none
module tb_disc_key_search_sequencer
   import keysearch_pkg::*;
;
   logic        ref_clk, rst_n, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready;
   logic        dma_done, sync_n, sec_n, rd_clk, rd_bit, gate, done;
   logic [7:0]  awaddr, araddr, dma_data;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   dma_req_s    dma_req;
   int          failures, comparisons, reads;

   disc_key_search_sequencer u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .dma_req(dma_req), .dma_done(dma_done),
      .dma_data(dma_data), .sector_minus_one_sync_n(sync_n),
      .sector_pulse_n(sec_n), .drive_read_clock(rd_clk),
      .drive_read_bit(rd_bit), .disc_read_gate(gate), .search_done(done));
   dma_memory_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n),
      .dma_req(dma_req), .dma_done(dma_done), .dma_data(dma_data));

   // 20 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Counts DMA reads
   always @(posedge ref_clk)
      if (dma_req.strobe === 1'b1 && dma_req.rd === 1'b1)
         reads++;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Write: both channels offered, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      check(bresp, (a > COUNT_ADDR) ? AXI_DECERR : AXI_OKAY);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      d = rdata;
      rready <= 1'b0;
      check(rresp, (a > COUNT_ADDR) ? AXI_DECERR : AXI_OKAY);
   endtask

   // Bounded wait for a level; a miss is a mismatch
   task automatic wait_hi(ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim)
      begin
         @(posedge ref_clk);
         n++;
      end
      check(s, 1'b1);
   endtask

   // Read clock runs only in frames, MSB first
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         rd_bit <= b[i];
         repeat (2) @(posedge ref_clk);
         rd_clk <= 1'b1;
         repeat (2) @(posedge ref_clk);
         rd_clk <= 1'b0;
      end
   endtask

   task automatic stop_test;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge ref_clk);
      failures++;
      stop_test();
   end

   // One disc key below the argument key, one above
   initial
   begin
      logic [31:0] d;
      logic [7:0]  k0, k1, q0, q1;
      int          best_key_number;
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, rd_clk, rd_bit} = '0;
      {sync_n, sec_n} = 2'b11;
      {failures, comparisons, reads} = '0;
      void'($urandom(46));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h10, d);
      check(d, 32'h0000_0000);
      wr(8'h14, 32'h0000_0001);
      for (int c = 0; c < 2; c++)
      begin
         k0 = 8'h80 + 8'($urandom_range(126));
         k1 = 8'($urandom);
         q0 = c ? k0 + 8'h01 : k0 - 8'h01 - 8'($urandom_range(126));
         q1 = 8'h01 | 8'($urandom);
         best_key_number = int'({q0, q1} < {k0, k1});
         u_mem.mem[9'h100] = 8'h00;
         u_mem.mem[9'h101] = 8'h01;
         u_mem.mem[9'h102] = 8'h01;
         u_mem.mem[9'h103] = k0;
         u_mem.mem[9'h104] = k1;
         wr(COUNT_ADDR, 32'h0104_0100);
         wr(CTRL_ADDR, 32'h0000_0001);
         sync_n <= 1'b0;
         wait_hi(gate, 3000);
         sync_n <= 1'b1;
         sec_n <= 1'b0;
         repeat (4) @(posedge ref_clk);
         sec_n <= 1'b1;
         repeat (31) send_byte(8'h00);
         send_byte(q0);
         send_byte(q1);
         rd_bit <= 1'($urandom);
         wait_hi(done, 3000);
         rd(RESULT_ADDR, d);
         check(d, {16'd1, 16'(best_key_number)});
         rd(STATUS_ADDR, d);
         check(d[11], 1'b1);
      end
      reads = 0;
      wr(CTRL_ADDR, 32'h0000_0003);
      repeat (200) @(posedge ref_clk);
      check(reads, 0);
      stop_test();
   end
endmodule
`default_nettype wire
